//--- logic/nine_bit_uart.sv
// Serial port for 11-bit frames with multiprocessor address filter.
// Assumes one 50 MHz clock, synchronous reset, plain register port.
//
// How it works
// - frame is start, eight data, ninth, stop
// - sent ninth bit follows tx_ninth_bit
// - mode 2 divides clock by 16 or 32
// - mode 3 rate from timer overflow
// - buffer write loads ninth bit, requests send
// - send starts after next counter rollover
// - start bit, then data, then shifting
// - first shift inserts stop, then zeros
// - bit count reaching TX_BITS ends send, sets tx flag
// - falling edge resets counter, fills ones
// - sample states 7,8,9, majority wins
// - non-zero start bit abandons frame
// - start at left end triggers final shift
// - load only if flag clear and filter passes
// - failed conditions discard; else store data
// - hunt again one bit time later
// - multiproc filter ignored outside modes 2, 3
// - multiproc accepts only matching address bytes
// - given address is value under mask
// - broadcast is value OR mask
// - reset clears address and mask
module nine_bit_uart
    import nine_bit_uart_pkg::*;
#(
    parameter int DIV_W = 16
)(
    input wire logic SYS_CLK_I,
    input wire logic SRST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic TIMER_OVF_I,
    input wire logic RXD_I,
    output logic TXD_O,
    output logic IRQ_O
);
    typedef enum {TX_IDLE, TX_WAIT, TX_START, TX_DATA} tx_state_t;
    typedef enum {RX_HUNT, RX_BITS, RX_TAIL} rx_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rx_buf;
        logic [7:0] addr;
        logic [7:0] mask;
        logic [DIV_W-1:0] div;
        logic [DIV_W-1:0] pre;
        logic [4:0] m2cnt;
        logic [3:0] tx_cnt;
        logic [3:0] rx_cnt;
        logic [8:0] tx_sh;
        logic [3:0] tx_bits;
        tx_state_t tx_st;
        logic tx_req;
        logic [8:0] rx_sh;
        rx_state_t rx_st;
        logic rx_prev;
        logic txd;
        logic irq;
        logic [7:0] rdata;
        logic [1:0] rxd_sync;
    } state_t;
    state_t r, nxt;

    logic rx_bit;
    logic tick;

    // =========================================================
    // Address recognition
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
        logic [7:0] bc;
        bc = v | m;
        addr_hit = (((a ^ v) & m) == 8'h00) || (((a ^ bc) & bc) == 8'h00);
    endfunction : addr_hit

    rx_sampler u_sampler (
        .clk_i(SYS_CLK_I),
        .rst_i(SRST_I),
        .tick_i(tick),
        .phase_i(r.rx_cnt),
        .line_i(r.rxd_sync[1]),
        .bit_o(rx_bit)
    );

    // =========================================================
    // Oversample tick: mode 2 fixed divide, mode 3 timer overflow
    always_comb begin
        if (r.ctrl[CTRL_MODE]) begin
            tick = TIMER_OVF_I;
        end else if (r.ctrl[CTRL_HALF_RATE]) begin
            tick = r.m2cnt[0];
        end else begin
            tick = 1'b1;
        end
    end
    // =========================================================
    // Next state
    always_comb begin
        logic rx_fall;
        logic tx_roll;
        logic rx_roll;
        logic pass;
        logic [8:0] rx_full;
        logic [7:0] rx_byte;
        rx_fall = 1'b0;
        tx_roll = 1'b0;
        rx_roll = 1'b0;
        pass = 1'b0;
        rx_full = 9'h000;
        rx_byte = 8'h00;
        nxt = r;
        nxt.rxd_sync = {r.rxd_sync[0], RXD_I};
        nxt.m2cnt = r.m2cnt + 5'h01;
        nxt.rdata = 8'h00;
        if (tick) begin
            nxt.tx_cnt = r.tx_cnt + 4'h1;
            nxt.rx_cnt = r.rx_cnt + 4'h1;
        end
        tx_roll = tick && (r.tx_cnt == OVS_LAST);
        rx_roll = tick && (r.rx_cnt == OVS_LAST);

        // Transmit path
        case (r.tx_st)
            TX_IDLE: begin
                nxt.txd = 1'b1;
            end
            TX_WAIT: begin
                if (tx_roll) begin
                    nxt.tx_st = TX_START;
                    nxt.txd = 1'b0;
                end
            end
            TX_START: begin
                if (tx_roll) begin
                    nxt.tx_st = TX_DATA;
                    nxt.txd = r.tx_sh[0];
                    nxt.tx_bits = 4'h0;
                end
            end
            TX_DATA: begin
                if (tx_roll) begin
                    // Stop bit enters on first shift, zeros after
                    nxt.tx_sh = {(r.tx_bits == 4'h0), r.tx_sh[8:1]};
                    nxt.tx_bits = r.tx_bits + 4'h1;
                    nxt.txd = r.tx_sh[1];
                    if (r.tx_bits == TX_BITS) begin
                        nxt.tx_st = TX_IDLE;
                        nxt.txd = 1'b1;
                        nxt.ctrl[CTRL_TX_DONE] = 1'b1;
                    end
                end
            end
            default: nxt.tx_st = TX_IDLE;
        endcase

        // Receive path
        rx_fall = r.rx_prev && !r.rxd_sync[1];
        if (tick) begin
            nxt.rx_prev = r.rxd_sync[1];
        end
        rx_full = {r.rx_sh[7:0], rx_bit};
        // First data bit sits highest, so the byte is bit-reversed
        for (int i = 0; i < 8; i++) begin
            rx_byte[i] = r.rx_sh[7-i];
        end
        case (r.rx_st)
            RX_HUNT: begin
                if (tick && rx_fall && r.ctrl[CTRL_RX_EN]) begin
                    nxt.rx_cnt = 4'h0;
                    nxt.rx_sh = 9'h1FF;
                    nxt.rx_st = RX_BITS;
                end
            end
            RX_BITS: begin
                if (rx_roll) begin
                    if (r.rx_sh == 9'h1FF && rx_bit) begin
                        nxt.rx_st = RX_HUNT;
                    end else if (!r.rx_sh[8]) begin
                        // Ninth bit is the last sample, start falls off the left
                        pass = !r.ctrl[CTRL_RX_DONE] && (!r.ctrl[CTRL_MULTIPROC] ||
                            (rx_bit && addr_hit(rx_byte, r.addr, r.mask)));
                        if (pass) begin
                            nxt.rx_buf = rx_byte;
                            nxt.ctrl[CTRL_RX_NINTH] = rx_bit;
                            nxt.ctrl[CTRL_RX_DONE] = 1'b1;
                        end
                        nxt.rx_sh = rx_full;
                        nxt.rx_st = RX_TAIL;
                    end else begin
                        nxt.rx_sh = rx_full;
                    end
                end
            end
            RX_TAIL: begin
                if (rx_roll) begin
                    nxt.rx_st = RX_HUNT;
                end
            end
            default: nxt.rx_st = RX_HUNT;
        endcase

        // Register port; hardware set wins over a software clear
        if (WR_I) begin
            case (ADDR_I)
                OFS_DATA: begin
                    nxt.tx_sh = {r.ctrl[CTRL_TX_NINTH], WDATA_I};
                    nxt.tx_st = TX_WAIT;
                end
                OFS_CTRL: begin
                    nxt.ctrl = WDATA_I | (nxt.ctrl & ~r.ctrl & 8'h03);
                end
                OFS_ADDR: nxt.addr = WDATA_I;
                OFS_MASK: nxt.mask = WDATA_I;
                default: nxt.div = r.div;
            endcase
        end
        if (RD_I) begin
            case (ADDR_I)
                OFS_DATA: nxt.rdata = r.rx_buf;
                OFS_CTRL: nxt.rdata = r.ctrl;
                OFS_ADDR: nxt.rdata = r.addr;
                OFS_MASK: nxt.rdata = r.mask;
                default: nxt.rdata = 8'h00;
            endcase
        end
        nxt.irq = nxt.ctrl[CTRL_RX_DONE] | nxt.ctrl[CTRL_TX_DONE];
    end

    // =========================================================
    // State register
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            r <= '0;
            r.ctrl <= CTRL_RST;
            r.addr <= ADDR_RST;
            r.mask <= MASK_RST;
            r.div <= DIV_W'(DIV_RST);
            r.tx_st <= TX_IDLE;
            r.rx_st <= RX_HUNT;
            r.txd <= 1'b1;
            r.rx_prev <= 1'b1;
            r.rxd_sync <= 2'b11;
            r.tx_sh <= 9'h1FF;
            r.rx_sh <= 9'h1FF;
        end else begin
            r <= nxt;
        end
    end

    assign TXD_O = r.txd;
    assign IRQ_O = r.irq;
    assign RDATA_O = r.rdata;

    // =========================================================
    // Assertions
    a_tx_idle_high: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        r.tx_st == TX_IDLE |-> ##1 (TXD_O || r.tx_st != TX_IDLE)) else $error("line not idle high");
    a_start_low: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        r.tx_st == TX_START |-> !TXD_O) else $error("start bit not low");
    a_tx_begins: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        (r.tx_st == TX_WAIT && tick && r.tx_cnt == OVS_LAST && !WR_I) |=> r.tx_st == TX_START)
        else $error("send did not start on rollover");
    a_tx_done_set: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        (r.tx_st == TX_DATA && tick && r.tx_cnt == OVS_LAST && r.tx_bits == TX_BITS && !WR_I)
        |=> (r.ctrl[CTRL_TX_DONE] && r.tx_st == TX_IDLE)) else $error("send end did not set tx flag");
    a_load_ninth: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        (WR_I && ADDR_I == OFS_DATA) |=> r.tx_sh[8] == $past(r.ctrl[CTRL_TX_NINTH]))
        else $error("ninth bit not loaded");
    a_rx_flag_hold: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        (r.ctrl[CTRL_RX_DONE] && !(WR_I && ADDR_I == OFS_CTRL)) |=> r.ctrl[CTRL_RX_DONE])
        else $error("rx flag dropped");
    a_irq_follows: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        IRQ_O == (r.ctrl[CTRL_RX_DONE] | r.ctrl[CTRL_TX_DONE])) else $error("irq mismatch");
    a_false_start: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        (r.rx_st == RX_BITS && r.rx_sh == 9'h1FF && tick && r.rx_cnt == OVS_LAST && rx_bit)
        |=> r.rx_st == RX_HUNT) else $error("false start kept");
    a_tail_hunt: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        (r.rx_st == RX_TAIL && tick && r.rx_cnt == OVS_LAST) |=> r.rx_st == RX_HUNT)
        else $error("no return to hunt");
    c_tx_frame: cover property (@(posedge SYS_CLK_I) $rose(r.ctrl[CTRL_TX_DONE]));
    c_rx_frame: cover property (@(posedge SYS_CLK_I) $rose(r.ctrl[CTRL_RX_DONE]));
    c_rx_filtered: cover property (@(posedge SYS_CLK_I) r.rx_st == RX_TAIL && !r.ctrl[CTRL_RX_DONE]);
endmodule : nine_bit_uart

//--- logic/nine_bit_uart_pkg.sv
// Package: constants for the 11-bit frame serial port.
// Assumes one system clock; registers reached over a plain strobe port.
package nine_bit_uart_pkg;
    // =========================================================
    // Register offsets
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_CTRL = 3'h1;
    localparam logic [2:0] OFS_ADDR = 3'h2;
    localparam logic [2:0] OFS_MASK = 3'h3;
    localparam logic [2:0] OFS_DIV = 3'h4;
    // =========================================================
    // Control register bit positions
    localparam int CTRL_RX_DONE = 0;
    localparam int CTRL_TX_DONE = 1;
    localparam int CTRL_RX_NINTH = 2;
    localparam int CTRL_TX_NINTH = 3;
    localparam int CTRL_RX_EN = 4;
    localparam int CTRL_MULTIPROC = 5;
    localparam int CTRL_MODE = 6;
    localparam int CTRL_HALF_RATE = 7;
    // =========================================================
    // Reset values and counts
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] SMP_A = 4'h7;
    localparam logic [3:0] SMP_B = 4'h8;
    localparam logic [3:0] SMP_C = 4'h9;
    // Shifts done after the first data bit when the last shift leaves the stop bit alone
    localparam logic [3:0] TX_BITS = 4'h8;
endpackage : nine_bit_uart_pkg

//--- logic/rx_sampler.sv
// Receive bit detector: three samples per bit time, majority vote.
// Assumes a synchronised line input and an oversample tick.
module rx_sampler
    import nine_bit_uart_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic [3:0] phase_i,
    input wire logic line_i,
    output logic bit_o
);
    typedef struct packed {
        logic [1:0] votes;
    } smp_t;
    smp_t s_r, s_nxt;

    // =========================================================
    // Majority over states seven, eight and nine
    always_comb begin
        s_nxt = s_r;
        if (tick_i && phase_i == SMP_A) begin
            s_nxt.votes = {1'b0, line_i};
        end else if (tick_i && (phase_i == SMP_B || phase_i == SMP_C)) begin
            s_nxt.votes = s_r.votes + {1'b0, line_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bit_o = s_r.votes[1];
endmodule : rx_sampler

//--- tb/nine_bit_uart_tb.sv
// Bench for the 11-bit frame serial port: table of frames, then corner cases.
// Assumes the peer model on the serial lines and a 50 MHz system clock.
module nine_bit_uart_tb
    import nine_bit_uart_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TOV = 2;
    typedef struct {
        logic [7:0] ctrl;
        logic [7:0] addr;
        logic [7:0] mask;
        logic [7:0] data;
        logic exp;
    } row_t;
    logic SYS_CLK_I = 1'b0;
    logic SRST_I = 1'b1;
    logic [2:0] ADDR_I = 3'h0;
    logic [7:0] WDATA_I = 8'h00;
    logic WR_I = 1'b0;
    logic RD_I = 1'b0;
    logic TIMER_OVF_I = 1'b0;
    logic [7:0] RDATA_O;
    logic RXD_I;
    logic TXD_O;
    logic IRQ_O;
    int tov_cnt = 0;
    int err_total = 0;
    int total_checks = 0;
    logic [7:0] rv;
    int n;
    int bc;
    row_t rows [9] = '{'{8'h10, 8'h00, 8'h00, 8'hA5, 1'b1}, '{8'h98, 8'h00, 8'h00, 8'h3C, 1'b1},
        '{8'h70, 8'h00, 8'h00, 8'h55, 1'b0}, '{8'h38, 8'hC0, 8'hFD, 8'hC2, 1'b1},
        '{8'h38, 8'hC0, 8'hFE, 8'hC2, 1'b0}, '{8'h38, 8'hC0, 8'hFE, 8'hFF, 1'b1},
        '{8'h38, 8'hC0, 8'hFD, 8'hC1, 1'b0}, '{8'h58, 8'h00, 8'h00, 8'h81, 1'b1},
        '{8'hB8, 8'h00, 8'h00, 8'h12, 1'b1}};
    nine_bit_uart nine_bit_uart_inst (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .TIMER_OVF_I(TIMER_OVF_I),
        .RXD_I(RXD_I), .TXD_O(TXD_O), .IRQ_O(IRQ_O));
    peer_uart peer_uart_inst (.clk_i(SYS_CLK_I), .txd_i(TXD_O), .rxd_o(RXD_I));
    // =========================================================
    // Clock and timer tick
    initial forever #10 SYS_CLK_I = ~SYS_CLK_I;
    always @(posedge SYS_CLK_I) begin
        tov_cnt <= (tov_cnt == TOV - 1) ? 0 : tov_cnt + 1;
        TIMER_OVF_I <= (tov_cnt == TOV - 1);
    end
    // =========================================================
    // Helpers
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    // Gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge SYS_CLK_I);
        WR_I <= 1'b0;
        @(posedge SYS_CLK_I);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge SYS_CLK_I);
        RD_I <= 1'b0;
        #1 d = RDATA_O;
        @(posedge SYS_CLK_I);
    endtask : rd
    task automatic stop_test();
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    // =========================================================
    // Watchdog: the whole run needs under 20000 cycles
    initial begin
        repeat (20000) @(posedge SYS_CLK_I);
        err_total++;
        stop_test();
    end
    // =========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge SYS_CLK_I);
        SRST_I <= 1'b0;
        @(posedge SYS_CLK_I);
        check(TXD_O, 1'b1);
        check(IRQ_O, 1'b0);
        for (int a = 0; a < 5; a++) begin
            rd(a[2:0], rv);
            check(rv, 8'h00);
        end
        foreach (rows[i]) begin
            bc = rows[i].ctrl[CTRL_MODE] ? 16 * TOV : (rows[i].ctrl[CTRL_HALF_RATE] ? 32 : 16);
            peer_uart_inst.bit_clks = bc;
            wr(OFS_ADDR, rows[i].addr);
            wr(OFS_MASK, rows[i].mask);
            wr(OFS_CTRL, rows[i].ctrl);
            n = peer_uart_inst.rx_count;
            wr(OFS_DATA, rows[i].data);
            for (int k = 0; k < 16 * bc && peer_uart_inst.rx_count == n; k++) @(posedge SYS_CLK_I);
            check(peer_uart_inst.rx_word, {rows[i].ctrl[CTRL_TX_NINTH], rows[i].data});
            check(peer_uart_inst.rx_frame_ok, 1'b1);
            repeat (bc) @(posedge SYS_CLK_I);
            rd(OFS_CTRL, rv);
            check(rv[CTRL_TX_DONE], 1'b1);
            check(IRQ_O, 1'b1);
            wr(OFS_CTRL, rows[i].ctrl);
            peer_uart_inst.send({rows[i].ctrl[CTRL_TX_NINTH], rows[i].data});
            repeat (2 * bc) @(posedge SYS_CLK_I);
            rd(OFS_CTRL, rv);
            check(rv[CTRL_RX_DONE], rows[i].exp);
            check(IRQ_O, rows[i].exp);
            if (rows[i].exp) begin
                check(rv[CTRL_RX_NINTH], rows[i].ctrl[CTRL_TX_NINTH]);
                rd(OFS_DATA, rv);
                check(rv, rows[i].data);
            end
            wr(OFS_CTRL, rows[i].ctrl);
        end
        // Second frame must be lost while the first is unread
        peer_uart_inst.bit_clks = 16;
        wr(OFS_CTRL, 8'h10);
        peer_uart_inst.send(9'h0A5);
        peer_uart_inst.send(9'h15A);
        repeat (32) @(posedge SYS_CLK_I);
        rd(OFS_DATA, rv);
        check(rv, 8'hA5);
        rd(OFS_CTRL, rv);
        check(rv[CTRL_RX_NINTH], 1'b0);
        wr(OFS_CTRL, 8'h10);
        peer_uart_inst.glitch(3);
        repeat (320) @(posedge SYS_CLK_I);
        rd(OFS_CTRL, rv);
        check(rv[CTRL_RX_DONE], 1'b0);
        peer_uart_inst.send(9'h1C3);
        repeat (32) @(posedge SYS_CLK_I);
        rd(OFS_DATA, rv);
        check(rv, 8'hC3);
        wr(OFS_CTRL, 8'h10);
        // Start bit within one rollover, done flag at the 11th
        wr(OFS_DATA, 8'hFF);
        n = 0;
        repeat (20) begin
            @(negedge SYS_CLK_I);
            if (TXD_O === 1'b0) n++;
        end
        check(n != 0, 1'b1);
        repeat (137) @(negedge SYS_CLK_I);
        check(IRQ_O, 1'b0);
        repeat (26) @(negedge SYS_CLK_I);
        check(IRQ_O, 1'b1);
        @(posedge SYS_CLK_I);
        wr(OFS_ADDR, 8'hC0);
        wr(OFS_MASK, 8'hFD);
        SRST_I <= 1'b1;
        repeat (2) @(posedge SYS_CLK_I);
        SRST_I <= 1'b0;
        @(posedge SYS_CLK_I);
        rd(OFS_ADDR, rv);
        check(rv, 8'h00);
        rd(OFS_MASK, rv);
        check(rv, 8'h00);
        check(IRQ_O, 1'b0);
        stop_test();
    end
endmodule : nine_bit_uart_tb

//--- tb/peer_uart.sv
// Far-side serial peer: sends 11-bit frames and decodes the port's output.
// Assumes the bench sets the bit length in system clocks; line idles high.
module peer_uart (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int bit_clks = 16;
    int rx_count = 0;
    logic [8:0] rx_word = 9'h000;
    logic rx_frame_ok = 1'b0;
    initial rxd_o = 1'b1;
    // =========================================================
    // Sending side
    task automatic send(input logic [8:0] word);
        logic [10:0] frame;
        frame = {1'b1, word, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd_o <= frame[i];
            repeat (bit_clks) @(posedge clk_i);
        end
    endtask : send
    // Short low pulse, too brief to pass the start-bit vote
    task automatic glitch(input int n);
        rxd_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask : glitch
    // =========================================================
    // Receiving side, samples mid-bit
    initial begin
        logic [10:0] frame;
        forever begin
            @(negedge txd_i);
            repeat (bit_clks / 2) @(posedge clk_i);
            for (int i = 0; i < 11; i++) begin
                frame[i] = txd_i;
                if (i < 10) repeat (bit_clks) @(posedge clk_i);
            end
            rx_word = frame[9:1];
            rx_frame_ok = !frame[0] && frame[10];
            rx_count++;
        end
    end
endmodule : peer_uart
